//--- verilog/dtc_timer.v
// Summary of operation
// - Two independent timers, zero and one, each a 16-bit count of low and high byte.
// - Timer function adds one per machine cycle, a twelfth of the clock.
// - Counter function adds one per falling edge on its own count pin.
// - Count pins are sampled once per machine cycle, at S5P2.
// - A fall is a high sample followed by a low sample next cycle.
// - After a fall the new count appears at S3P1 of the third cycle.
// - Count-source bit one selects pin edges, zero selects machine cycles.
// - With run and gate set, counting proceeds only while the gate pin is high.
// - Gate pin zero serves timer zero, gate pin one serves timer one.
// - Gated counting measures high pulse width in cycles or edges.
// - Each timer has source, gate and a two-bit mode field.
// - Modes: 00 prescaled 13-bit, 01 16-bit, 10 8-bit reload, 11 special.
// - Gate, source and mode bits of both timers clear on reset.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`include "dtc_map.vh"

module dtc_timer #(
   parameter MC_LEN = `DTC_MC_LEN
) (
   input wire pclk,              // Core clock, the oscillator rate
   input wire presetn,           // Async reset, active low
   input wire psel,              // APB select
   input wire penable,           // APB access phase
   input wire pwrite,            // APB direction, high for write
   input wire [7:0] paddr,       // APB byte address
   input wire [31:0] pwdata,     // APB write data
   output reg [31:0] prdata,     // APB read data
   output wire pready,           // APB ready, always high
   output reg pslverr,           // APB error on unmapped address
   input wire count_pin_zero,    // External count input, timer zero
   input wire count_pin_one,     // External count input, timer one
   input wire gate_pin_zero,     // External gate input, timer zero
   input wire gate_pin_one,      // External gate input, timer one
   output wire irq               // Level interrupt, unmasked overflow
);

   // ==========================================================
   // Declarations
   reg [3:0] phase_reg;
   reg [3:0] phase_next;
   reg [1:0] run_reg;
   reg [7:0] mode_reg;
   reg [15:0] cnt0_reg;
   reg [15:0] cnt0_next;
   reg [15:0] cnt1_reg;
   reg [15:0] cnt1_next;
   reg [1:0] stat_reg;
   reg [1:0] stat_next;
   reg [1:0] mask_reg;
   reg [1:0] samp_reg;
   reg [1:0] fall_reg;
   reg [1:0] fall_next;
   reg [1:0] ovf_evt;
   reg [16:0] step0;
   reg [16:0] step1;
   reg [8:0] th0_sum;
   reg [31:0] rd_data;
   reg rd_hit;
   wire [3:0] pin_raw;
   wire [3:0] pin_lvl;
   wire tick_s3p1;
   wire tick_s5p2;
   wire wr_en;
   wire rd_setup;
   wire [3:0] ctl0;
   wire [3:0] ctl1;
   wire [1:0] mode0;
   wire [1:0] mode1;
   wire [1:0] cnt_src;
   wire [1:0] gate_bit;
   wire [1:0] count_ok;
   wire [1:0] inc_en;
   wire spl0;

   // ==========================================================
   // Functions
   // One count step for the given mode; bit 16 flags overflow
   function [16:0] dtc_step;
      input [15:0] c;
      input [1:0] m;
      input inc;
      reg [13:0] s13;
      reg [8:0] lo;
      begin
         s13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
         lo = {1'b0, c[7:0]} + 9'h001;
         dtc_step = {1'b0, c};
         if (inc) begin
            case (m)
               `DTC_MODE_PRE: dtc_step = {s13[13], s13[12:5], c[7:5], s13[4:0]};
               `DTC_MODE_16: dtc_step = {1'b0, c} + 17'h00001;
               `DTC_MODE_RLD: begin
                  if (lo[8]) begin
                     dtc_step = {1'b1, c[15:8], c[15:8]};
                  end else begin
                     dtc_step = {1'b0, c[15:8], lo[7:0]};
                  end
               end
               default: dtc_step = {lo[8], c[15:8], lo[7:0]};
            endcase
         end
      end
   endfunction

   // Address decode for the write paths; the read path decodes paddr in its own case statement
   function dtc_hit;
      input [7:0] a;
      input [7:0] off;
      begin
         dtc_hit = (a == off);
      end
   endfunction

   // ==========================================================
   // Pin synchronisers
   // Three stages; the filtered level moves only when stages two and
   // three agree, so a single metastable sample never counts.
   assign pin_raw = {gate_pin_one, gate_pin_zero, count_pin_one, count_pin_zero};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         reg s1_reg;
         reg s2_reg;
         reg s3_reg;
         reg lvl_reg;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               lvl_reg <= 1'b0;
            end else begin
               s1_reg <= pin_raw[gi];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  lvl_reg <= s3_reg;
               end
            end
         end
         assign pin_lvl[gi] = lvl_reg;
      end
   endgenerate

   // ==========================================================
   // Machine cycle phase counter
   // twelve clocks per cycle
   always @* begin
      if (phase_reg == MC_LEN[3:0] - 4'h1) begin
         phase_next = 4'h0;
      end else begin
         phase_next = phase_reg + 4'h1;
      end
   end

   assign tick_s3p1 = (phase_reg == `DTC_PH_S3P1);
   assign tick_s5p2 = (phase_reg == `DTC_PH_S5P2);

   // ==========================================================
   // Control field decode
   assign ctl0 = mode_reg[3:0];
   assign ctl1 = mode_reg[`DTC_T1_SHIFT+3:`DTC_T1_SHIFT];
   assign mode0 = {ctl0[`DTC_F_MHI], ctl0[`DTC_F_MLO]};
   assign mode1 = {ctl1[`DTC_F_MHI], ctl1[`DTC_F_MLO]};
   assign cnt_src = {ctl1[`DTC_F_CT], ctl0[`DTC_F_CT]};
   assign gate_bit = {ctl1[`DTC_F_GATE], ctl0[`DTC_F_GATE]};
   assign spl0 = (mode0 == `DTC_MODE_SPL);

   // gate holds off counting while its pin is low
   // gate pin i pairs with timer i
   // gated count measures the high pulse
   assign count_ok = run_reg & (~gate_bit | pin_lvl[3:2]);

   // source select picks pin edges or machine cycles
   // run bit low blocks every increment
   assign inc_en = {2{tick_s3p1}} & count_ok & (~cnt_src | fall_reg);

   // ==========================================================
   // Falling edge detection on count pins
   // high sample then low sample
   always @* begin
      fall_next = fall_reg;
      if (tick_s3p1) begin
         fall_next = 2'h0;
      end
      if (tick_s5p2) begin
         fall_next = samp_reg & ~pin_lvl[1:0];
      end
   end

   // ==========================================================
   // Count update
   // A fall seen at S5P2 of the second cycle lands at S3P1 of the third.
   always @* begin
      step0 = dtc_step(cnt0_reg, mode0, inc_en[0]);
      // Timer one stops while in the special mode
      step1 = dtc_step(cnt1_reg, mode1, inc_en[1] & (mode1 != `DTC_MODE_SPL));
      cnt0_next = step0[15:0];
      cnt1_next = step1[15:0];
      ovf_evt = {step1[16], step0[16]};
      th0_sum = {1'b0, cnt0_reg[15:8]} + 9'h001;
      // Special mode: high byte of timer zero runs on machine cycles under
      // run bit one and borrows the overflow flag of timer one
      if (spl0 && tick_s3p1 && run_reg[1]) begin
         cnt0_next[15:8] = th0_sum[7:0];
         ovf_evt[`DTC_ST_OVF1] = ovf_evt[`DTC_ST_OVF1] | th0_sum[8];
      end
      // Software write wins over a count in the same cycle
      if (wr_en && dtc_hit(paddr, `DTC_OFF_CNT0)) begin
         cnt0_next = pwdata[15:0];
      end
      if (wr_en && dtc_hit(paddr, `DTC_OFF_CNT1)) begin
         cnt1_next = pwdata[15:0];
      end
   end

   // ==========================================================
   // Status: write one to clear, a new event wins over the clear
   always @* begin
      stat_next = stat_reg;
      if (wr_en && dtc_hit(paddr, `DTC_OFF_STAT)) begin
         stat_next = stat_reg & ~pwdata[1:0];
      end
      stat_next = stat_next | ovf_evt;
   end

   assign irq = |(stat_reg & mask_reg);

   // ==========================================================
   // APB decode
   // Zero wait states; read data is captured in the setup cycle
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;

   always @* begin
      rd_data = 32'h00000000;
      rd_hit = 1'b1;
      case (paddr)
         `DTC_OFF_CTRL: rd_data = {30'h00000000, run_reg};
         `DTC_OFF_MODE: rd_data = {24'h000000, mode_reg};
         `DTC_OFF_CNT0: rd_data = {16'h0000, cnt0_reg};
         `DTC_OFF_CNT1: rd_data = {16'h0000, cnt1_reg};
         `DTC_OFF_STAT: rd_data = {30'h00000000, stat_reg};
         `DTC_OFF_MASK: rd_data = {30'h00000000, mask_reg};
         default: rd_hit = 1'b0;
      endcase
   end

   // ==========================================================
   // Registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= 4'h0;
         run_reg <= `DTC_RST_CTRL;
         mode_reg <= `DTC_RST_MODE;
         cnt0_reg <= `DTC_RST_CNT;
         cnt1_reg <= `DTC_RST_CNT;
         stat_reg <= `DTC_RST_STAT;
         mask_reg <= `DTC_RST_MASK;
         samp_reg <= 2'h0;
         fall_reg <= 2'h0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         cnt0_reg <= cnt0_next;
         cnt1_reg <= cnt1_next;
         stat_reg <= stat_next;
         fall_reg <= fall_next;
         if (tick_s5p2) begin
            samp_reg <= pin_lvl[1:0];
         end
         if (wr_en && dtc_hit(paddr, `DTC_OFF_CTRL)) begin
            run_reg <= pwdata[1:0];
         end
         if (wr_en && dtc_hit(paddr, `DTC_OFF_MODE)) begin
            mode_reg <= pwdata[7:0];
         end
         if (wr_en && dtc_hit(paddr, `DTC_OFF_MASK)) begin
            mask_reg <= pwdata[1:0];
         end
         if (rd_setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_data;
            pslverr <= ~rd_hit;
         end
      end
   end

endmodule

//--- verilog/dtc_map.vh
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// ==========================================================
// Register byte offsets
`define DTC_OFF_CTRL 8'h00
`define DTC_OFF_MODE 8'h04
`define DTC_OFF_CNT0 8'h08
`define DTC_OFF_CNT1 8'h0c
`define DTC_OFF_STAT 8'h10
`define DTC_OFF_MASK 8'h14

// ==========================================================
// Field positions inside one timer nibble of the mode register
`define DTC_F_GATE 3
`define DTC_F_CT 2
`define DTC_F_MHI 1
`define DTC_F_MLO 0
`define DTC_T1_SHIFT 4

// Mode codes
`define DTC_MODE_PRE 2'h0
`define DTC_MODE_16 2'h1
`define DTC_MODE_RLD 2'h2
`define DTC_MODE_SPL 2'h3

// Status bit positions
`define DTC_ST_OVF0 0
`define DTC_ST_OVF1 1

// ==========================================================
// Reset values
`define DTC_RST_CTRL 2'h0
`define DTC_RST_MODE 8'h00
`define DTC_RST_CNT 16'h0000
`define DTC_RST_STAT 2'h0
`define DTC_RST_MASK 2'h0

// ==========================================================
// Timing: oscillator clocks per machine cycle and phase slots
`define DTC_MC_LEN 12
`define DTC_PH_S3P1 4'h4
`define DTC_PH_S5P2 4'h9

`endif

//--- test/dtc_timer_props.sv
`timescale 1ns/1ns
`include "dtc_map.vh"
// ==========
// Port checks for the timer block
module dtc_timer_props #(
   parameter MC_LEN = 12
) (
   input wire pclk, // Clock
   input wire presetn, // Reset, low
   input wire psel, // Select
   input wire penable, // Access
   input wire pwrite, // Direction
   input wire [7:0] paddr, // Address
   input wire [31:0] pwdata, // Write data
   input wire [31:0] prdata, // Read data
   input wire pready, // Ready
   input wire pslverr, // Error
   input wire irq // Interrupt
);
   // Access phase decode
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   wire map = paddr <= `DTC_OFF_MASK && paddr[1:0] == 2'h0;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_high: assert property (pready) else $error("pready low");
   a_map_ok: assert property (acc && map |-> !pslverr) else $error("mapped access flagged");
   a_unmap_err: assert property (acc && !map |-> pslverr) else $error("unmapped not flagged");
   a_unmap_zero: assert property (rd && !map |-> prdata == 32'h0) else $error("unmapped data");
   a_cnt_width: assert property (rd && paddr[7:3] == 5'h01 |-> prdata[31:16] == 16'h0)
      else $error("count wider than 16 bits");
   a_mode_width: assert property (rd && paddr == `DTC_OFF_MODE |-> prdata[31:8] == 24'h0)
      else $error("mode read wide");
   a_rdata_hold: assert property (acc ##1 !(psel && !penable) |-> $stable(prdata))
      else $error("read data moved");
   // Zero mask must drop the line at once, whatever the status holds
   a_mask_quiet: assert property (acc && pwrite && paddr == `DTC_OFF_MASK &&
      pwdata[1:0] == 2'h0 |=> !irq) else $error("irq with mask clear");
endmodule

//--- test/dtc_pins.sv
`timescale 1ns/1ns
// ==========
// Far-side count and gate pins
module dtc_pins (
   input wire pclk, // Stimulus clock
   output reg count_zero, // Count pin, timer zero
   output reg count_one, // Count pin, timer one
   output reg gate_zero, // Gate pin, timer zero
   output reg gate_one // Gate pin, timer one
);
   initial begin
      count_zero = 1'b0;
      count_one = 1'b0;
      gate_zero = 1'b0;
      gate_one = 1'b0;
   end
   // Two machine cycles each level, so the sampler cannot miss a fall
   task fall(input integer which, input integer n);
      integer i;
      for (i = 0; i < n; i = i + 1) begin
         @(posedge pclk);
         if (which == 0) count_zero <= 1'b1;
         else count_one <= 1'b1;
         repeat (24) @(posedge pclk);
         if (which == 0) count_zero <= 1'b0;
         else count_one <= 1'b0;
         repeat (24) @(posedge pclk);
      end
   endtask
   task gate(input integer which, input integer cyc);
      begin
         @(posedge pclk);
         if (which == 0) gate_zero <= 1'b1;
         else gate_one <= 1'b1;
         repeat (cyc) @(posedge pclk);
         if (which == 0) gate_zero <= 1'b0;
         else gate_one <= 1'b0;
      end
   endtask
endmodule

//--- test/dtc_timer_bench.sv
`timescale 1ns/1ns
`include "dtc_map.vh"
// ==========
// Bench top
module dtc_timer_bench;
   localparam MC_LEN = 12;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, irq, c0, c1, g0, g1;
   integer error_cnt = 0;
   integer cmp_count = 0;
   reg [31:0] rv;
   reg re;
   reg [7:0] a;
   always #4 pclk = ~pclk;
   dtc_timer #(.MC_LEN(MC_LEN)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .count_pin_zero(c0), .count_pin_one(c1),
      .gate_pin_zero(g0), .gate_pin_one(g1), .irq(irq));
   dtc_pins pins (.pclk(pclk), .count_zero(c0), .count_one(c1), .gate_zero(g0),
      .gate_one(g1));
   // Compare and count
   task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // One APB transfer; an idle edge first keeps drives one per step
   task apb(input w, input [7:0] ad, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= ad;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rv = prdata;
         re = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdchk(input [63:0] nm, input [7:0] ad, input [31:0] exp);
      begin
         apb(1'b0, ad, 32'h0);
         chk(nm, rv, exp);
      end
   endtask
   // Timer zero for k machine cycles; accesses land 3 edges apart
   task run0(input [3:0] m, input [15:0] s, input integer k, input [15:0] exp);
      begin
         apb(1'b1, `DTC_OFF_CNT0, {16'h0, s});
         apb(1'b1, `DTC_OFF_MODE, {28'h0, m});
         apb(1'b1, `DTC_OFF_CTRL, 32'h1);
         repeat (MC_LEN * k - 3) @(posedge pclk);
         apb(1'b1, `DTC_OFF_CTRL, 32'h0);
         rdchk("cnt0", `DTC_OFF_CNT0, {16'h0, exp});
      end
   endtask
   task close_out;
      begin
         $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
         if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Watchdog
   initial begin
      #80000;
      error_cnt = error_cnt + 1;
      close_out;
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (a = 8'h00; a <= 8'h14; a = a + 8'h04) rdchk("reset", a, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk("slverr", {31'h0, re}, 32'h1);
      $display("reset test done");
      run0(4'h1, 16'h0000, 10, 16'h000a);
      run0(4'h1, 16'h00ff, 1, 16'h0100);
      run0(4'h0, 16'h00ff, 1, 16'h01e0);
      run0(4'h2, 16'h50ff, 1, 16'h5050);
      // Split mode: the low byte wraps alone while run bit one stays low
      run0(4'h3, 16'h12fe, 3, 16'h1201);
      apb(1'b1, `DTC_OFF_CNT1, 32'h1234);
      // Ungated timer function, so only the stop mode can hold the count
      apb(1'b1, `DTC_OFF_MODE, 32'h30);
      apb(1'b1, `DTC_OFF_CTRL, 32'h2);
      repeat (36) @(posedge pclk);
      apb(1'b1, `DTC_OFF_CTRL, 32'h0);
      rdchk("cnt1", `DTC_OFF_CNT1, 32'h1234);
      apb(1'b1, `DTC_OFF_STAT, 32'h3);
      run0(4'h1, 16'hffff, 1, 16'h0000);
      rdchk("stat", `DTC_OFF_STAT, 32'h1);
      chk("irq", {31'h0, irq}, 32'h0);
      // The line follows a register write only after the edge settles
      apb(1'b1, `DTC_OFF_MASK, 32'h1);
      @(negedge pclk);
      chk("irq", {31'h0, irq}, 32'h1);
      apb(1'b1, `DTC_OFF_MASK, 32'h0);
      @(negedge pclk);
      chk("irq", {31'h0, irq}, 32'h0);
      apb(1'b1, `DTC_OFF_MASK, 32'h1);
      apb(1'b1, `DTC_OFF_STAT, 32'h1);
      @(negedge pclk);
      chk("irq", {31'h0, irq}, 32'h0);
      rdchk("stat", `DTC_OFF_STAT, 32'h0);
      $display("mode test done");
      apb(1'b1, `DTC_OFF_CNT0, 32'h0);
      apb(1'b1, `DTC_OFF_CNT1, 32'h0);
      apb(1'b1, `DTC_OFF_MODE, 32'h55);
      apb(1'b1, `DTC_OFF_CTRL, 32'h3);
      pins.fall(0, 3);
      pins.fall(1, 2);
      repeat (36) @(posedge pclk);
      apb(1'b1, `DTC_OFF_CTRL, 32'h0);
      rdchk("cnt0", `DTC_OFF_CNT0, 32'h3);
      rdchk("cnt1", `DTC_OFF_CNT1, 32'h2);
      pins.fall(0, 1);
      rdchk("cnt0", `DTC_OFF_CNT0, 32'h3);
      $display("counter test done");
      apb(1'b1, `DTC_OFF_CNT0, 32'h0);
      apb(1'b1, `DTC_OFF_CNT1, 32'h0);
      apb(1'b1, `DTC_OFF_MODE, 32'h99);
      apb(1'b1, `DTC_OFF_CTRL, 32'h3);
      repeat (60) @(posedge pclk);
      pins.gate(0, 5 * MC_LEN);
      repeat (24) @(posedge pclk);
      apb(1'b1, `DTC_OFF_CTRL, 32'h0);
      // A gate high for five machine cycles admits exactly five counts
      rdchk("gate0", `DTC_OFF_CNT0, 32'h5);
      rdchk("cnt1", `DTC_OFF_CNT1, 32'h0);
      $display("gate test done");
      // A reset after both timers are stopped must clear the gate, source and mode fields again
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("mode", `DTC_OFF_MODE, 32'h0);
      $display("second reset test done");
      close_out;
   end
endmodule
bind dtc_timer dtc_timer_props #(.MC_LEN(MC_LEN)) u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
